/* File: core/sfia_pkg.sv */
// package: register map, command fields and timing for the fabric indirect access bridge
`default_nettype none
package sfia_pkg;
	localparam logic [7:0] ADDR_CMD        = 8'h00;
	localparam logic [7:0] ADDR_DATA       = 8'h04;
	localparam logic [7:0] ADDR_MAC_LO     = 8'h08;
	localparam logic [7:0] ADDR_MAC_HI     = 8'h0C;
	localparam logic [7:0] ADDR_FC_BASE    = 8'h10;
	localparam logic [7:0] ADDR_WIN_BASE   = 8'h80;
	localparam logic [7:0] ADDR_WIN_MASK   = 8'h80;
	localparam int         CMD_BUSY_BIT    = 31;
	localparam int         CMD_RNW_BIT     = 30;
	localparam int         CMD_INC_BIT     = 29;
	localparam int         CMD_DEC_BIT     = 28;
	localparam int         CMD_BE_LSB      = 16;
	localparam logic [3:0] ALL_LANES       = 4'hF;
	localparam logic [31:0] CMD_RESET      = 32'h0000_0000;
	localparam logic [31:0] DATA_RESET     = 32'h0000_0000;
	localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;
	localparam int         FABRIC_LAT_NS   = 30;
	localparam int         CLK_PERIOD_NS   = 10;
	localparam int         FABRIC_LAT_CYC  = (FABRIC_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0]
	{
		SFIA_IDLE = 3'b001,
		SFIA_REQ  = 3'b010,
		SFIA_WAIT = 3'b100
	} sfia_state_type;
endpackage
`default_nettype wire

/* File: core/sfia_window_map.sv */
// direct-window offset to fabric register address table, registered output
`default_nettype none
module sfia_window_map
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic [4:0]  i_slot,
	output logic      [15:0] o_fabric_addr
);
	import sfia_pkg::*;

	// only a fixed subset of fabric registers is reachable through the window
	function automatic logic [15:0] map_slot(input logic [4:0] s);
		logic [15:0] a;
		a = 16'h0000;
		if (s < 5'h08)
			a = {11'h000, s};
		else if (s < 5'h10)
			a = 16'h0400 + {11'h000, s - 5'h08};
		else if (s < 5'h18)
			a = 16'h0800 + {11'h000, s - 5'h10};
		else
			a = 16'h0C00 + {11'h000, s - 5'h18};
		return a;
	endfunction

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_fabric_addr <= 16'h0000;
		else
			o_fabric_addr <= map_slot(i_slot);
	end
endmodule
`default_nettype wire

/* File: core/sfia_bridge.sv */
// top: host-facing indirect access bridge to the switch fabric register space
// What this block does
// - busy held until transfer finishes
// - write done steps address up/down
// - window write loads address, lanes, busy
// - window maps a fixed subset only
// - read data stored on the same edge that busy clears
// - auto-step data read launches next read
// - flow control, command, data, MAC mapped
// - indirect path reaches all fabric registers
`default_nettype none
module sfia_bridge
#(
	parameter int PORTS = 3
)
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	output logic             o_fab_req,
	output logic             o_fab_rnw,
	output logic      [15:0] o_fab_addr,
	output logic      [3:0]  o_fab_be,
	output logic      [31:0] o_fab_wdata,
	input  wire logic        i_fab_ack,
	input  wire logic [31:0] i_fab_rdata,
	output logic      [47:0] o_mac_addr,
	output logic      [3*PORTS-1:0] o_manual_fc
);
	import sfia_pkg::*;

	typedef struct packed
	{
		sfia_state_type     st;
		logic [31:0]        cmd;
		logic [31:0]        data;
		logic [31:0]        rdata;
		logic               req;
		logic               win_pend;
		logic [47:0]        mac;
		logic [3*PORTS-1:0] fc;
	} sfia_regs_type;

	sfia_regs_type r, n;
	logic [15:0]   win_addr;

	sfia_window_map u_map
	(
		.i_sys_clk     (i_sys_clk),
		.i_rst_b       (i_rst_b),
		.i_slot        (i_reg_addr[6:2]),
		.o_fabric_addr (win_addr)
	);

	wire logic busy    = r.cmd[CMD_BUSY_BIT];
	wire logic step_up = r.cmd[CMD_INC_BIT];
	wire logic step_dn = r.cmd[CMD_DEC_BIT];
	wire logic is_win  = (i_reg_addr & ADDR_WIN_MASK) == ADDR_WIN_BASE;

	function automatic logic [31:0] stepped(input logic [31:0] c, input logic up, input logic dn);
		logic [31:0] o;
		o = c;
		if (up)
			o[15:0] = c[15:0] + 16'h0001;
		else if (dn)
			o[15:0] = c[15:0] - 16'h0001;
		return o;
	endfunction

	always_comb
	begin
		n = r;
		n.rdata = RD_UNMAPPED;
		// register reads; data read in read auto-step launches the next read
		if (i_reg_rd)
		begin
			if (i_reg_addr == ADDR_CMD)
				n.rdata = r.cmd;
			else if (i_reg_addr == ADDR_DATA)
			begin
				n.rdata = r.data;
				if (!busy && r.cmd[CMD_RNW_BIT] && (step_up || step_dn))
				begin
					n.cmd = stepped(r.cmd, step_up, step_dn);
					n.cmd[CMD_BUSY_BIT] = 1'b1;
				end
			end
			else if (i_reg_addr == ADDR_MAC_LO)
				n.rdata = r.mac[31:0];
			else if (i_reg_addr == ADDR_MAC_HI)
				n.rdata = {16'h0000, r.mac[47:32]};
			else if (i_reg_addr >= ADDR_FC_BASE && i_reg_addr < ADDR_FC_BASE + 8'(4 * PORTS))
				n.rdata = {29'h0, r.fc[3*((i_reg_addr - ADDR_FC_BASE) >> 2) +: 3]};
		end
		// writes are only honoured when idle; busy-time writes are dropped
		if (i_reg_wr && !busy && !r.win_pend)
		begin
			if (i_reg_addr == ADDR_CMD)
				n.cmd = i_reg_wdata;
			else if (i_reg_addr == ADDR_DATA)
			begin
				n.data = i_reg_wdata;
				if (!r.cmd[CMD_RNW_BIT] && (step_up || step_dn))
					n.cmd[CMD_BUSY_BIT] = 1'b1;
			end
			else if (i_reg_addr == ADDR_MAC_LO)
				n.mac[31:0] = i_reg_wdata;
			else if (i_reg_addr == ADDR_MAC_HI)
				n.mac[47:32] = i_reg_wdata[15:0];
			else if (i_reg_addr >= ADDR_FC_BASE && i_reg_addr < ADDR_FC_BASE + 8'(4 * PORTS))
				n.fc[3*((i_reg_addr - ADDR_FC_BASE) >> 2) +: 3] = i_reg_wdata[2:0];
			else if (is_win)
			begin
				n.data = i_reg_wdata;
				n.win_pend = 1'b1;
			end
		end
		// table output is one cycle late, so the window command lands next cycle
		if (r.win_pend)
		begin
			n.win_pend = 1'b0;
			n.cmd[15:0] = win_addr;
			n.cmd[CMD_BE_LSB +: 4] = ALL_LANES;
			n.cmd[CMD_RNW_BIT] = 1'b0;
			n.cmd[CMD_INC_BIT] = 1'b0;
			n.cmd[CMD_DEC_BIT] = 1'b0;
			n.cmd[CMD_BUSY_BIT] = 1'b1;
		end
		n.req = 1'b0;
		case (r.st)
			SFIA_IDLE:
				if (busy)
				begin
					n.st  = SFIA_REQ;
					n.req = 1'b1;
				end
			SFIA_REQ:
				n.st = SFIA_WAIT;
			SFIA_WAIT:
				if (i_fab_ack)
				begin
					n.st = SFIA_IDLE;
					n.cmd[CMD_BUSY_BIT] = 1'b0;
					if (r.cmd[CMD_RNW_BIT])
						n.data = i_fab_rdata;
					else
						n.cmd = stepped(n.cmd, step_up, step_dn);
				end
			default:
				n.st = SFIA_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			r.st       <= SFIA_IDLE;
			r.cmd      <= CMD_RESET;
			r.data     <= DATA_RESET;
			r.rdata    <= RD_UNMAPPED;
			r.req      <= 1'b0;
			r.win_pend <= 1'b0;
			r.mac      <= 48'h0000_0000_0000;
			r.fc       <= '0;
		end
		else
			r <= n;
	end

	assign o_reg_rdata = r.rdata;
	assign o_fab_req   = r.req;
	assign o_fab_rnw   = r.cmd[CMD_RNW_BIT];
	assign o_fab_addr  = r.cmd[15:0];
	assign o_fab_be    = r.cmd[CMD_BE_LSB +: 4];
	assign o_fab_wdata = r.data;
	assign o_mac_addr  = r.mac;
	assign o_manual_fc = r.fc;

	a_busy_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(r.st == SFIA_WAIT && !i_fab_ack) |=> busy)
		else $error("busy dropped before ack");
	a_busy_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(r.st == SFIA_WAIT && i_fab_ack) |=> !busy)
		else $error("busy not cleared after ack");
	a_read_data: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(r.st == SFIA_WAIT && i_fab_ack && o_fab_rnw) |=> (r.data == $past(i_fab_rdata)))
		else $error("read data not captured");
	a_write_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(r.st == SFIA_WAIT && i_fab_ack && !o_fab_rnw && step_up) |=> (o_fab_addr == $past(o_fab_addr) + 16'h0001))
		else $error("address not stepped up after write");
	a_window_launch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_reg_wr && is_win && !busy && !r.win_pend) |=> ##1 (busy && !o_fab_rnw && o_fab_be == ALL_LANES))
		else $error("window write did not launch");
	a_window_data: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_reg_wr && is_win && !busy && !r.win_pend) |=> (o_fab_wdata == $past(i_reg_wdata)))
		else $error("window data lost");
	a_read_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_reg_rd && i_reg_addr == ADDR_DATA && !busy && !r.win_pend && o_fab_rnw && (step_up || step_dn)) |=>
		(busy && o_fab_addr == ($past(step_up) ? $past(o_fab_addr) + 16'h0001 : $past(o_fab_addr) - 16'h0001)))
		else $error("auto read not restarted");
	a_req_launch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		(r.st == SFIA_IDLE && busy) |=> o_fab_req ##1 !o_fab_req)
		else $error("fabric request not issued");
	c_single_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) (r.st == SFIA_WAIT && i_fab_ack && o_fab_rnw));
	c_auto_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) (r.st == SFIA_WAIT && i_fab_ack && !o_fab_rnw && step_up));
	c_window: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) (r.win_pend));
endmodule
`default_nettype wire

/* File: bench/sfia_fabric_model.sv */
// fabric-side register model answering the bridge's transfers, fast or slow by address
`default_nettype none
module sfia_fabric_model
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_req,
	input  wire logic        i_rnw,
	input  wire logic [15:0] i_addr,
	input  wire logic [3:0]  i_be,
	input  wire logic [31:0] i_wdata,
	output logic             o_ack,
	output logic      [31:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// plain array so every free simulator takes it; cleared so unwritten lanes read as zero
	logic [31:0] mem [0:65535];
	initial
	begin
		for (int k = 0; k < 65536; k++)
			mem[k] = 32'h0000_0000;
		o_ack = 1'b0;
		o_rdata = 32'h0;
		forever
		begin
			@(posedge i_sys_clk);
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata; // read data carries nothing outside the ack cycle
			if (i_req === 1'b1)
			begin
				repeat (i_addr[0] ? 4 : 0) @(posedge i_sys_clk); // odd addresses answer slowly
				for (int b = 0; b < 4; b++)
					if (!i_rnw && i_be[b])
						mem[i_addr][8*b+:8] = i_wdata[8*b+:8];
				o_ack <= 1'b1;
				o_rdata <= mem[i_addr];
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench: host register accesses through the fabric indirect access bridge
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sfia_pkg::*;
	localparam logic [31:0] BSY = 32'h1 << CMD_BUSY_BIT;
	localparam logic [31:0] RNW = 32'h1 << CMD_RNW_BIT;
	localparam logic [31:0] INC = 32'h1 << CMD_INC_BIT;
	localparam logic [31:0] DEC = 32'h1 << CMD_DEC_BIT;
	logic        clk, rst_b, wr_s, rd_s, req, rnw, ack, f_rnw;
	logic [7:0]  addr;
	logic [31:0] wd, rdata, fwd, frd, f_wd, d;
	logic [15:0] fa, f_addr;
	logic [3:0]  be, f_be;
	logic [47:0] mac;
	logic [8:0]  fc;
	int          failures = 0, n_tests = 0, n_req = 0, n0;
	sfia_bridge dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr_s),
		.i_reg_rd(rd_s), .o_reg_rdata(rdata), .o_fab_req(req), .o_fab_rnw(rnw), .o_fab_addr(fa), .o_fab_be(be),
		.o_fab_wdata(fwd), .i_fab_ack(ack), .i_fab_rdata(frd), .o_mac_addr(mac), .o_manual_fc(fc));
	sfia_fabric_model fab (.i_sys_clk(clk), .i_req(req), .i_rnw(rnw), .i_addr(fa), .i_be(be), .i_wdata(fwd),
		.o_ack(ack), .o_rdata(frd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (req === 1'b1)
		begin
			n_req <= n_req + 1;
			f_addr <= fa;
			f_be <= be;
			f_rnw <= rnw;
			f_wd <= fwd;
		end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// window writes raise busy two cycles late, so polling starts after that
	task automatic idle;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 40; k++)
		begin
			rd(ADDR_CMD, d);
			if (d[CMD_BUSY_BIT] === 1'b0)
				return;
		end
		failures++;
		final_report;
	endtask
	logic [7:0]  wa [2] = '{8'h84, 8'hFC};
	logic [15:0] we [2] = '{16'h0001, 16'h0C07};
	initial
	begin
		rst_b = 1'b0;
		addr = 8'h00;
		wd = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(ADDR_CMD, d);
		`CHK("cmd reset", CMD_RESET, d)
		rd(ADDR_DATA, d);
		`CHK("data reset", DATA_RESET, d)
		$display("test reset done");
		wr(ADDR_DATA, 32'h1234_5678);
		wr(ADDR_CMD, BSY | 32'h0003_0011);
		idle;
		`CHK("wr addr", 16'h0011, f_addr)
		`CHK("wr lanes", 4'h3, f_be)
		`CHK("wr dir", 1'b0, f_rnw)
		`CHK("wr data", 32'h1234_5678, f_wd)
		wr(ADDR_CMD, BSY | RNW | 32'h0000_0011);
		idle;
		`CHK("rd dir", 1'b1, f_rnw)
		rd(ADDR_DATA, d);
		`CHK("rd data", 32'h0000_5678, d)
		$display("test single done");
		wr(ADDR_CMD, INC | 32'h000F_0020);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_DATA, 32'hA000_0000 + i);
			idle;
			`CHK("inc addr", 16'h0020 + i, f_addr)
		end
		rd(ADDR_CMD, d);
		`CHK("inc cmd", INC | 32'h000F_0023, d)
		wr(ADDR_CMD, DEC | 32'h000F_0031);
		wr(ADDR_DATA, 32'h0000_000B);
		idle;
		rd(ADDR_CMD, d);
		`CHK("dec cmd", DEC | 32'h000F_0030, d)
		wr(ADDR_CMD, BSY | RNW | INC | 32'h000F_0020);
		idle;
		for (int i = 0; i < 3; i++)
		begin
			if (i == 2)
				wr(ADDR_CMD, RNW | 32'h000F_0022);
			n0 = n_req;
			rd(ADDR_DATA, d);
			`CHK("seq rd", 32'hA000_0000 + i, d)
			idle;
		end
		`CHK("no extra rd", n0, n_req)
		$display("test step done");
		for (int j = 0; j < 2; j++)
		begin
			wr(wa[j], 32'hC0DE_0000 + j);
			idle;
			`CHK("win addr", we[j], f_addr)
			`CHK("win lanes", ALL_LANES, f_be)
			`CHK("win dir", 1'b0, f_rnw)
			`CHK("win data", 32'hC0DE_0000 + j, f_wd)
		end
		$display("test window done");
		wr(ADDR_MAC_LO, 32'h89AB_CDEF);
		wr(ADDR_MAC_HI, 32'h0000_4567);
		for (int p = 0; p < 3; p++)
			wr(ADDR_FC_BASE + 8'(4 * p), 32'(p + 5));
		#1;
		`CHK("mac", 48'h4567_89AB_CDEF, mac)
		`CHK("flow ctl", 9'h1F5, fc)
		rd(ADDR_FC_BASE + 8'h08, d);
		`CHK("fc2 rd", 32'h0000_0007, d)
		rd(ADDR_MAC_HI, d);
		`CHK("mac hi rd", 32'h0000_4567, d)
		rd(ADDR_MAC_LO, d);
		`CHK("mac lo rd", 32'h89AB_CDEF, d)
		rd(8'h40, d);
		`CHK("unmapped", RD_UNMAPPED, d)
		$display("test direct done");
		final_report;
	end
endmodule
`default_nettype wire
